/* hdl/pdwt_defines.svh */
`ifndef PDWT_DEFINES_SVH
`define PDWT_DEFINES_SVH

// register byte offsets
`define PDWT_OFF_W0_BASE    8'h00
`define PDWT_OFF_W0_MASK    8'h04
`define PDWT_OFF_W0_TRANS   8'h08
`define PDWT_OFF_W1_BASE    8'h10
`define PDWT_OFF_W1_MASK    8'h14
`define PDWT_OFF_W1_TRANS   8'h18
`define PDWT_OFF_HOLE_CTRL  8'h20
`define PDWT_OFF_STATUS     8'h24
`define PDWT_WIN_STRIDE     8'h10

// window base/control fields
`define PDWT_BASE_START_HI  31
`define PDWT_BASE_START_LO  20
`define PDWT_BASE_EN_BIT    19
`define PDWT_BASE_SG_BIT    18
`define PDWT_BASE_END_HI    11
`define PDWT_BASE_END_LO    0

// size mask and translation base fields
`define PDWT_MASK_HI        30
`define PDWT_MASK_LO        20
`define PDWT_TRANS_HI       30
`define PDWT_TRANS_LO       9

// page table entry: frame number position inside the selected quadword
`define PDWT_PFN_LSB        1
`define PDWT_PFN_W          19

// reset values
`define PDWT_RST_WORD       32'h0000_0000

`endif

/* hdl/pdwt_pkg.sv */
package pdwt_pkg;

    typedef logic [31:0] pdwt_word_t;
    typedef logic [33:0] pdwt_sys_addr_t;

    // one window's register set, only implemented bits held
    typedef struct packed {
        logic [11:0] start;
        logic        enable;
        logic        sg_sel;
        logic [11:0] stop;
        logic [10:0] size_mask;
        logic [21:0] trans_base;   // bits 30:9
    } pdwt_win_s;

    // system bus request toward memory
    typedef struct packed {
        logic           is_pte;
        logic           win;
        pdwt_sys_addr_t addr;
    } pdwt_sys_req_s;

    typedef enum logic [1:0] {
        PDWT_IDLE     = 2'b01,
        PDWT_PTE_WAIT = 2'b10
    } pdwt_state_e;

endpackage

/* hdl/pdwt_translate.sv */
// Our own choices: the plain strobed port and the placing of the registers.
`include "pdwt_defines.svh"

module pdwt_translate
    import pdwt_pkg::*;
#(
    parameter logic [31:0] HOLE0_BASE = 32'h000A_0000,
    parameter logic [31:0] HOLE0_SIZE = 32'h0002_0000,
    parameter logic [31:0] HOLE1_BASE = 32'h000C_0000,
    parameter logic [31:0] HOLE1_SIZE = 32'h0004_0000
) (
    input  wire logic          i_core_clk,
    input  wire logic          i_rstn,
    input  wire logic [7:0]    i_reg_addr,
    input  wire logic [31:0]   i_reg_wdata,
    input  wire logic          i_reg_wr,
    input  wire logic          i_reg_rd,
    output logic [31:0]        o_reg_rdata,
    input  wire logic          i_pci_req,
    input  wire logic [31:0]   i_pci_addr,
    output logic               o_pci_claim,
    output logic               o_busy,
    output logic               o_sys_req,
    output pdwt_sys_req_s      o_sys,
    input  wire logic          i_pte_valid,
    input  wire logic [127:0]  i_pte_data
);

    logic [1:0]     rst_sync_q;
    logic           rstn;
    pdwt_win_s      win_q [2];
    logic [1:0]     hole_en_q;
    logic [31:0]    rdata_d;
    logic [31:0]    rdata_q;
    pdwt_state_e    state_q;
    logic [31:0]    req_addr_q;
    logic           req_win_q;
    logic           claim_q;
    logic           sys_req_q;
    pdwt_sys_req_s  sys_q;
    logic [5:0]     status_q;

    // reset release through two flops
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rstn = rst_sync_q[1];

    // register writes
    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            win_q[0]  <= '0;
            win_q[1]  <= '0;
            hole_en_q <= 2'h0;
        end else if (i_reg_wr) begin
            for (int w = 0; w < 2; w++) begin
                if (i_reg_addr == `PDWT_OFF_W0_BASE + 8'(w) * `PDWT_WIN_STRIDE) begin
                    win_q[w].start  <= i_reg_wdata[`PDWT_BASE_START_HI:`PDWT_BASE_START_LO];
                    win_q[w].enable <= i_reg_wdata[`PDWT_BASE_EN_BIT];
                    win_q[w].sg_sel <= i_reg_wdata[`PDWT_BASE_SG_BIT];
                    win_q[w].stop   <= i_reg_wdata[`PDWT_BASE_END_HI:`PDWT_BASE_END_LO];
                end
                if (i_reg_addr == `PDWT_OFF_W0_MASK + 8'(w) * `PDWT_WIN_STRIDE) begin
                    win_q[w].size_mask <= i_reg_wdata[`PDWT_MASK_HI:`PDWT_MASK_LO];
                end
                if (i_reg_addr == `PDWT_OFF_W0_TRANS + 8'(w) * `PDWT_WIN_STRIDE) begin
                    win_q[w].trans_base <= i_reg_wdata[`PDWT_TRANS_HI:`PDWT_TRANS_LO];
                end
            end
            if (i_reg_addr == `PDWT_OFF_HOLE_CTRL) begin
                hole_en_q <= i_reg_wdata[1:0];
            end
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_d = `PDWT_RST_WORD;
        for (int w = 0; w < 2; w++) begin
            if (i_reg_addr == `PDWT_OFF_W0_BASE + 8'(w) * `PDWT_WIN_STRIDE) begin
                rdata_d = {win_q[w].start, win_q[w].enable, win_q[w].sg_sel,
                           6'h00, win_q[w].stop};
            end
            if (i_reg_addr == `PDWT_OFF_W0_MASK + 8'(w) * `PDWT_WIN_STRIDE) begin
                rdata_d = {1'b0, win_q[w].size_mask, 20'h00000};
            end
            if (i_reg_addr == `PDWT_OFF_W0_TRANS + 8'(w) * `PDWT_WIN_STRIDE) begin
                rdata_d = {1'b0, win_q[w].trans_base, 9'h000};
            end
        end
        if (i_reg_addr == `PDWT_OFF_HOLE_CTRL) begin
            rdata_d = {30'h0000_0000, hole_en_q};
        end
        if (i_reg_addr == `PDWT_OFF_STATUS) begin
            rdata_d = {26'h000_0000, status_q};
        end
    end

    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= `PDWT_RST_WORD;
        end else if (i_reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= `PDWT_RST_WORD;
        end
    end
    assign o_reg_rdata = rdata_q;

    // a stray mask bit above a gap is ignored, so the size stays a power of two
    function automatic logic [10:0] clean_mask(input logic [10:0] m);
        logic [10:0] c;
        c[0] = m[0];
        for (int i = 1; i < 11; i++) begin
            c[i] = m[i] & c[i-1];
        end
        return c;
    endfunction

    function automatic pdwt_sys_addr_t direct_addr(input pdwt_win_s w, input logic [31:0] a);
        logic [10:0] m;
        logic [10:0] hi;
        m  = clean_mask(w.size_mask);
        hi = (w.trans_base[21:11] & ~m) | (a[30:20] & m);
        return {3'h0, hi, a[19:5], 5'h00};
    endfunction

    function automatic pdwt_sys_addr_t pte_addr(input pdwt_win_s w, input logic [31:0] a);
        logic [10:0] m;
        logic [10:0] mid;
        m   = clean_mask(w.size_mask);
        mid = (w.trans_base[10:0] & ~m) | (a[30:20] & m);
        return {3'h0, w.trans_base[20:11], mid, a[19:14], 4'h0};
    endfunction

    logic [1:0]  hit;
    logic        in_hole;
    logic        sel_win;
    logic        any_hit;
    pdwt_win_s   sel;
    logic [63:0] pte_qw;

    for (genvar g = 0; g < 2; g++) begin : g_win
        assign hit[g] = win_q[g].enable &&
                        (i_pci_addr[31:20] >= win_q[g].start) &&
                        (i_pci_addr[31:20] <= win_q[g].stop);
    end

    assign in_hole = (hole_en_q[0] && (i_pci_addr - HOLE0_BASE) < HOLE0_SIZE) ||
                     (hole_en_q[1] && (i_pci_addr - HOLE1_BASE) < HOLE1_SIZE);
    // windows never overlap when set up right; window 0 wins otherwise
    assign sel_win = !hit[0];
    assign sel     = win_q[sel_win];
    assign any_hit = (|hit) && !in_hole;

    // requests arriving while busy are dropped; the caller watches o_busy
    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q    <= PDWT_IDLE;
            req_addr_q <= 32'h0000_0000;
            req_win_q  <= 1'b0;
            claim_q    <= 1'b0;
            sys_req_q  <= 1'b0;
            sys_q      <= '0;
        end else begin
            claim_q   <= 1'b0;
            sys_req_q <= 1'b0;
            unique case (state_q)
                PDWT_IDLE: begin
                    if (i_pci_req && any_hit) begin
                        claim_q    <= 1'b1;
                        sys_req_q  <= 1'b1;
                        req_addr_q <= i_pci_addr; // keeps bit 13 for the entry pick
                        req_win_q  <= sel_win;
                        sys_q.win  <= sel_win;
                        if (sel.sg_sel) begin
                            sys_q.is_pte <= 1'b1;
                            sys_q.addr   <= pte_addr(sel, i_pci_addr);
                            state_q      <= PDWT_PTE_WAIT;
                        end else begin
                            sys_q.is_pte <= 1'b0;
                            sys_q.addr   <= direct_addr(sel, i_pci_addr);
                        end
                    end
                end
                PDWT_PTE_WAIT: begin
                    if (i_pte_valid) begin
                        sys_req_q    <= 1'b1;
                        sys_q.is_pte <= 1'b0;
                        sys_q.win    <= req_win_q;
                        sys_q.addr   <= {pte_qw[`PDWT_PFN_LSB +: `PDWT_PFN_W],
                                         req_addr_q[12:0], 2'h0};
                        state_q      <= PDWT_IDLE;
                    end
                end
            endcase
        end
    end

    assign pte_qw = req_addr_q[13] ? i_pte_data[127:64] : i_pte_data[63:0];

    // status: last decode outcome and busy
    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            status_q <= 6'h00;
        end else begin
            status_q[0] <= (state_q == PDWT_PTE_WAIT) && !i_pte_valid ||
                           (state_q == PDWT_IDLE) && i_pci_req && any_hit && sel.sg_sel;
            if (state_q == PDWT_IDLE && i_pci_req) begin
                status_q[1] <= any_hit;
                status_q[2] <= sel_win;
                status_q[3] <= any_hit && sel.sg_sel;
                status_q[4] <= (|hit) && in_hole;
                status_q[5] <= !(|hit);
            end
        end
    end

    assign o_pci_claim = claim_q;
    assign o_sys_req   = sys_req_q;
    assign o_sys       = sys_q;
    assign o_busy      = status_q[0];

endmodule

/* sim/pdwt_translate_sva.sv */
module pdwt_translate_sva
    import pdwt_pkg::*;
(
    input wire logic          i_core_clk,
    input wire logic          i_rstn,
    input wire logic          i_reg_rd,
    input wire logic [31:0]   o_reg_rdata,
    input wire logic          i_pci_req,
    input wire logic [31:0]   i_pci_addr,
    input wire logic          o_pci_claim,
    input wire logic          o_busy,
    input wire logic          o_sys_req,
    input wire pdwt_sys_req_s o_sys,
    input wire logic          i_pte_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] pa_q;
    // keeps the taken request, so the late final address can be tied to it
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn)
            pa_q <= 32'h0;
        else if (i_pci_req && !o_busy)
            pa_q <= i_pci_addr;
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    a_claim_has_cause: assert property (o_pci_claim |-> $past(i_pci_req) && !$past(o_busy))
        else $error("claim without a taken request");
    a_sys_has_cause: assert property (o_sys_req |-> $past(i_pci_req) || $past(i_pte_valid))
        else $error("system request without cause");
    a_claim_with_sys: assert property (o_pci_claim |-> o_sys_req)
        else $error("claim without system request");
    a_direct_addr: assert property (o_pci_claim && !o_sys.is_pte |-> o_sys.addr[33:31] == 3'h0
        && o_sys.addr[4:0] == 5'h00 && o_sys.addr[19:5] == pa_q[19:5])
        else $error("direct address fields wrong");
    a_pte_addr: assert property (o_pci_claim && o_sys.is_pte |-> o_busy && o_sys.addr[3:0] == 4'h0
        && o_sys.addr[33:31] == 3'h0 && o_sys.addr[9:4] == pa_q[19:14])
        else $error("entry address fields wrong");
    a_pte_to_final: assert property (o_busy && i_pte_valid |=> o_sys_req && !o_sys.is_pte && !o_busy)
        else $error("entry return not followed by final address");
    a_busy_holds: assert property (o_busy && !i_pte_valid |=> o_busy)
        else $error("busy dropped before entry returned");
    a_final_offset: assert property (o_sys_req && !o_sys.is_pte && !o_pci_claim |->
        o_sys.addr[14:2] == pa_q[12:0] && o_sys.addr[1:0] == 2'h0)
        else $error("final address offset wrong");
    a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    c_direct: cover property (o_pci_claim && !o_sys.is_pte);
    c_table: cover property (o_pci_claim && o_sys.is_pte);
    c_final: cover property (o_busy && i_pte_valid);
endmodule

/* sim/pdwt_mem_model.sv */
module pdwt_mem_model
    import pdwt_pkg::*;
(
    input  wire logic          i_core_clk,
    input  wire logic          i_rstn,
    input  wire logic          i_sys_req,
    input  wire pdwt_sys_req_s i_sys,
    input  wire logic [3:0]    i_delay,
    input  wire logic [18:0]   i_pfn0,
    input  wire logic [18:0]   i_pfn1,
    output logic               o_pte_valid,
    output logic [127:0]       o_pte_data
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt <= 0;
            o_pte_valid <= 1'b0;
            o_pte_data <= '1;
        end else begin
            cnt <= (i_sys_req && i_sys.is_pte) ? int'(i_delay) + 1 : (cnt > 0 ? cnt - 1 : 0);
            o_pte_valid <= (cnt == 1);
            // outside the return the data lines toggle, so the entry shows again every second cycle after it
            o_pte_data <= (cnt == 1) ? {44'h0, i_pfn1, 1'b0, 44'h0, i_pfn0, 1'b0}
                                     : ~o_pte_data;
        end
    end
endmodule

/* sim/tb_pci_dma_window_translate.sv */
module tb_pci_dma_window_translate;
    import pdwt_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, pci_req = 0, claim, busy, sys_req, pte_valid;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, pci_addr = 32'h0, m, t, e, p;
    logic [127:0] pte_data;
    logic [3:0] delay = 4'h0;
    pdwt_sys_req_s sys;
    int error_cnt = 0, comparisons = 0;
    localparam logic [18:0] PFN0 = 19'h0ABCD, PFN1 = 19'h05432;
    pdwt_translate dut_u (.i_core_clk(clk), .i_rstn(rstn), .i_reg_addr(reg_addr),
        .i_reg_wdata(wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata),
        .i_pci_req(pci_req), .i_pci_addr(pci_addr), .o_pci_claim(claim), .o_busy(busy),
        .o_sys_req(sys_req), .o_sys(sys), .i_pte_valid(pte_valid), .i_pte_data(pte_data));
    pdwt_mem_model mem_u (.i_core_clk(clk), .i_rstn(rstn), .i_sys_req(sys_req), .i_sys(sys),
        .i_delay(delay), .i_pfn0(PFN0), .i_pfn1(PFN1), .o_pte_valid(pte_valid),
        .o_pte_data(pte_data));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic finish_test;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(40'(rdata), 40'(x));
    endtask
    function automatic logic [35:0] dexp(input logic w, input logic [31:0] a, tb, mk);
        return {1'b0, w, 3'h0, (tb[30:20] & ~mk[30:20]) | (a[30:20] & mk[30:20]), a[19:5], 5'h00};
    endfunction
    task automatic pci(input logic [31:0] a, input logic c, input logic [35:0] x);
        @(posedge clk);
        pci_req <= 1'b1;
        pci_addr <= a;
        @(posedge clk);
        pci_req <= 1'b0;
        pci_addr <= ~a;
        #1 chk({claim, sys_req, c ? sys : 36'h0}, {c, c, x});
    endtask
    task automatic sg(input logic [31:0] a, input logic [3:0] d);
        int n;
        delay <= d;
        pci(a, 1'b1, {2'b11, 3'h0, 10'h0A0, (11'h0 & ~11'h1) | (a[30:20] & 11'h1),
            a[19:14], 4'h0});
        pci(32'h0060_0040, 1'b0, 36'h0);
        n = 0;
        while (!(sys_req === 1'b1 && sys.is_pte === 1'b0) && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        chk({sys_req, busy, sys}, {2'b10, 2'b01, a[13] ? PFN1 : PFN0, a[12:0], 2'b00});
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 3; i++) rd_chk(8'(i * 4), 32'h0);
        for (int i = 0; i < 4; i++) wr_reg(8'h10 + 8'(i * 4), 32'hFFFF_FFFF);
        rd_chk(8'h10, 32'hFFFC_0FFF);
        rd_chk(8'h14, 32'h7FF0_0000);
        rd_chk(8'h18, 32'h7FFF_FE00);
        rd_chk(8'h1C, 32'h0);
        for (int k = 0; k < 12; k++) begin
            e = 32'((1 << k) - 1);
            m = e << 20;
            t = 32'h7FF0_0000 & ~m;
            wr_reg(8'h00, {12'h000, 2'b10, 6'h0, e[11:0]});
            wr_reg(8'h04, m);
            wr_reg(8'h08, t);
            p = (e << 20) | 32'h0005_A5A4;
            pci(p, 1'b1, dexp(1'b0, p, t, m));
            pci(32'h0001_2340, 1'b1, dexp(1'b0, 32'h0001_2340, t, m));
            pci(p + 32'h0010_0000, 1'b0, 36'h0);
        end
        wr_reg(8'h20, 32'h3);
        rd_chk(8'h20, 32'h3);
        pci(32'h000A_1000, 1'b0, 36'h0);
        pci(32'h000C_0040, 1'b0, 36'h0);
        wr_reg(8'h20, 32'h0);
        pci(32'h000A_1000, 1'b1, dexp(1'b0, 32'h000A_1000, 32'h0, m));
        wr_reg(8'h00, 32'h0000_07FF);
        pci(32'h000A_1000, 1'b0, 36'h0);
        wr_reg(8'h00, 32'h0068_000D);
        wr_reg(8'h04, 32'h0070_0000);
        wr_reg(8'h08, 32'h0C80_0000);
        wr_reg(8'h10, 32'h0C8C_00C9);
        wr_reg(8'h14, 32'h0010_0000);
        wr_reg(8'h18, 32'h0A00_0000);
        sg(32'h0C81_2340, 4'h0);
        sg(32'h0C9F_C150, 4'hA);
        p = 32'h00DF_FFE0;
        pci(p, 1'b1, dexp(1'b0, p, 32'h0C80_0000, 32'h0070_0000));
        pci(32'h0C7F_FFE0, 1'b0, 36'h0);
        rd_chk(8'h24, 32'h0000_0024);
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
endmodule
bind pdwt_translate pdwt_translate_sva chk_u (.i_core_clk, .i_rstn, .i_reg_rd, .o_reg_rdata,
    .i_pci_req, .i_pci_addr, .o_pci_claim, .o_busy, .o_sys_req, .o_sys, .i_pte_valid);
